// File: common/msmm_map.svh
// Purpose: constants of the sample multiplex mapper
// Assumes: 250 MHz core clock
// Notes: definitions only
`ifndef MSMM_MAP_SVH
`define MSMM_MAP_SVH
// ************************************************************
// clock and rates
// ************************************************************
`define MSMM_CLK_HZ 28'hEE6B280
`define MSMM_BASE441_HZ 18'hAC44
`define MSMM_BASE48_HZ 18'hBB80
`define MSMM_ACC_W 28
`define MSMM_RATE_W 18
// ************************************************************
// link layout
// ************************************************************
`define MSMM_SAMPLE_W 24
`define MSMM_SLOT_W 6
`define MSMM_STD_LAST_SLOT 6'h3F
`define MSMM_NAT_LAST_SLOT 6'h1F
// ************************************************************
// clock recovery lock window
// ************************************************************
`define MSMM_LOCK_MIN_HZ 28'h00061A8
`define MSMM_LOCK_MAX_HZ 28'h0030D40
`define MSMM_MIN_PERIOD_CYC (`MSMM_CLK_HZ / `MSMM_LOCK_MAX_HZ)
`define MSMM_MAX_PERIOD_CYC (`MSMM_CLK_HZ / `MSMM_LOCK_MIN_HZ)
`define MSMM_DRIFT_CYC 16'h0010
`define MSMM_SYNC_FRAMES 3'h4
`endif

// File: common/msmm_pkg.sv
// Purpose: types of the sample multiplex mapper
// Assumes: nothing
// Notes: encodings match the mode input pins
`default_nettype none
package msmm_pkg;
	typedef enum logic [1:0] {
		RATE_SINGLE = 2'h0,
		RATE_DOUBLE = 2'h1,
		RATE_QUAD = 2'h2
	} msmm_rate_t;
	typedef enum logic {
		FMT_STANDARD = 1'h0,
		FMT_NATIVE = 1'h1
	} msmm_fmt_t;
	typedef enum logic [1:0] {
		LOCK_NONE = 2'h0,
		LOCK_VALID = 2'h1,
		LOCK_SYNC = 2'h2
	} msmm_lock_t;
endpackage : msmm_pkg
`default_nettype wire

// File: common/msmm_lock_if.sv
// Purpose: carrier between mapper core and lock meter
// Assumes: single clock domain
// Notes: frameStart and refTick are one-cycle pulses
`default_nettype none
interface msmm_lock_if;
	import msmm_pkg::*;
	logic frameStart;
	logic refTick;
	msmm_lock_t lockState;
	modport meter(input frameStart, input refTick, output lockState);
	modport user(output frameStart, output refTick, input lockState);
endinterface : msmm_lock_if
`default_nettype wire

// File: core/msmm_lock.sv
// Purpose: lock and sync meter on the recovered frame rate
// Assumes: frameStart pulses once per link frame
// Notes: drift is tracked frame to frame, not against a fixed rate
`include "msmm_map.svh"
`default_nettype none
module msmm_lock
	import msmm_pkg::*;
#(
	parameter int unsigned MAX_PERIOD = int'(`MSMM_MAX_PERIOD_CYC)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	msmm_lock_if.meter bus
);
	// ************************************************************
	// period measure and state
	// ************************************************************
	msmm_lock_t state, next_state;
	logic [15:0] cnt, next_cnt, lastPeriod, next_lastPeriod, diff;
	logic [1:0] ticks, next_ticks, curTicks;
	logic [2:0] syncRun, next_syncRun;
	logic inRange, steady, tickOk;
	localparam logic [15:0] MAXP = 16'(MAX_PERIOD);
	localparam logic [15:0] MINP = 16'(`MSMM_MIN_PERIOD_CYC);

	assign bus.lockState = state;

	always_comb begin
		next_state = state;
		next_lastPeriod = lastPeriod;
		next_syncRun = syncRun;
		next_cnt = (cnt <= MAXP) ? cnt + 16'h0001 : cnt;
		inRange = (cnt >= MINP) && (cnt <= MAXP); // R13
		diff = (cnt > lastPeriod) ? cnt - lastPeriod : lastPeriod - cnt;
		steady = inRange && (diff <= `MSMM_DRIFT_CYC); // R13
		curTicks = (bus.refTick && ticks != 2'h3) ? ticks + 2'h1 : ticks;
		tickOk = (curTicks == 2'h1);
		next_ticks = curTicks;
		if (bus.frameStart) begin
			next_cnt = 16'h0001;
			next_lastPeriod = cnt;
			next_ticks = 2'h0;
			next_syncRun = !tickOk ? 3'h0 : (syncRun == 3'h7 ? syncRun : syncRun + 3'h1);
			case (state) // R14
				LOCK_NONE: begin
					if (steady) next_state = LOCK_VALID;
				end
				LOCK_VALID: begin
					if (!steady) next_state = LOCK_NONE;
					else if (tickOk && syncRun >= `MSMM_SYNC_FRAMES - 3'h1) next_state = LOCK_SYNC;
				end
				LOCK_SYNC: begin
					if (!steady) next_state = LOCK_NONE;
					else if (!tickOk) next_state = LOCK_VALID;
				end
				default: begin
					next_state = LOCK_NONE;
				end
			endcase
		end else if (cnt > MAXP) begin
			// reference gone: no frame within the slowest legal period
			next_state = LOCK_NONE; // R13
			next_syncRun = 3'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= LOCK_NONE;
			cnt <= 16'h0000;
			lastPeriod <= 16'h0000;
			ticks <= 2'h0;
			syncRun <= 3'h0;
		end else if (clkEn) begin
			state <= next_state;
			cnt <= next_cnt;
			lastPeriod <= next_lastPeriod;
			ticks <= next_ticks;
			syncRun <= next_syncRun;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || !clkEn);

	AST_LOCK_IN_WINDOW: assert property ( // R13
		(state == LOCK_VALID && $past(state) == LOCK_NONE)
			|-> ($past(cnt) >= MINP && $past(cnt) <= MAXP))
		else $error("lock entered outside frequency window");
	AST_LOCK_TIMEOUT: assert property ( // R13
		(cnt > MAXP && !bus.frameStart) |=> state == LOCK_NONE)
		else $error("lock held with no reference");
	AST_SYNC_FROM_LOCK: assert property ( // R14
		(state == LOCK_SYNC && $past(state) != LOCK_SYNC) |-> $past(state) == LOCK_VALID)
		else $error("sync reached without lock");
	CV_SYNC: cover property (state == LOCK_VALID ##1 state == LOCK_SYNC);
endmodule : msmm_lock
`default_nettype wire

// File: core/msmm_top.sv
// Purpose: maps multi-rate logical channels onto link channel slots and back
// Assumes: router answers a slot request in the same cycle as the request
// Notes: link inputs are sampled on clk through two flip-flops
// Operation
// [R01] double rate runs internal sample clock at twice the base rate
// [R02] samples stay 24 bits wide in every rate mode
// [R03] double rate travels multiplexed in standard frame or natively
// [R04] double rate standard frame: one logical channel on two slots, 32 channels
// [R05] quad rate standard frame: one logical channel on four slots, 16 channels
// [R06] multiplexed high rates keep the link frame at base rate
// [R07] quad rate only by four-way multiplex, never a native frame
// [R08] successive samples of one channel fill group members in order
// [R09] multiplexing only moves samples, values never change
// [R10] standard frame carries up to 64 channels at base rate
// [R11] native frame carries 32 channels, receiver detects it itself
// [R12] controller must set multiplexed rate mode on every device
// [R13] clock recovery locks 25 to 200 kHz and tracks drift
// [R14] input state reported as no lock, lock or sync
// [R15] quad rate runs internal sample clock at four times base rate
`include "msmm_map.svh"
`default_nettype none
module msmm_top
	import msmm_pkg::*;
#(
	parameter int unsigned LOCK_MAX_PERIOD = int'(`MSMM_MAX_PERIOD_CYC)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [1:0] rateMode,
	input wire logic frameFormat,
	input wire logic base48k,
	input wire logic linkClk,
	input wire logic [`MSMM_SLOT_W-1:0] linkRxSlot,
	input wire logic [`MSMM_SAMPLE_W-1:0] linkRxData,
	input wire logic linkRxNative,
	output logic linkTxValid,
	output logic [`MSMM_SLOT_W-1:0] linkTxSlot,
	output logic [`MSMM_SAMPLE_W-1:0] linkTxData,
	output logic linkTxNative,
	output logic txReq,
	output logic [`MSMM_SLOT_W-1:0] txReqChan,
	output logic [1:0] txReqPhase,
	input wire logic [`MSMM_SAMPLE_W-1:0] txData,
	output logic rxValid,
	output logic [`MSMM_SLOT_W-1:0] rxChan,
	output logic [1:0] rxPhase,
	output logic [`MSMM_SAMPLE_W-1:0] rxData,
	output logic rxNativeSeen,
	output logic sampleTick,
	output logic [`MSMM_RATE_W-1:0] sampleRateHz,
	output logic [1:0] lockState
);
	// ************************************************************
	// link input synchroniser
	// ************************************************************
	logic [31:0] syncA, syncB;
	logic prevClk, linkEdge, sNative, rxNat;
	logic [`MSMM_SLOT_W-1:0] sSlot;
	logic [`MSMM_SAMPLE_W-1:0] sData;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncA <= 32'h00000000;
			syncB <= 32'h00000000;
			prevClk <= 1'b0;
		end else if (clkEn) begin
			syncA <= {linkClk, linkRxNative, linkRxSlot, linkRxData};
			syncB <= syncA;
			prevClk <= syncB[31];
		end
	end

	assign linkEdge = syncB[31] & ~prevClk;
	assign sNative = syncB[30];
	assign sSlot = syncB[29:24];
	assign sData = syncB[23:0];
	// a native frame marker on slot 0 overrides the configured mode at once
	assign rxNat = (sSlot == 6'h00) ? sNative : rxNativeSeen; // R11

	// ************************************************************
	// internal sample clock
	// ************************************************************
	logic [`MSMM_RATE_W-1:0] baseHz, next_sampleRateHz;
	logic [1:0] rateShift, phaseMask;
	logic [`MSMM_ACC_W-1:0] acc [2];
	logic [`MSMM_ACC_W-1:0] next_acc [2];
	logic [`MSMM_ACC_W-1:0] sum [2];
	logic [1:0] next_tick;
	logic baseTick;

	always_comb begin
		baseHz = base48k ? `MSMM_BASE48_HZ : `MSMM_BASE441_HZ;
		case (rateMode)
			RATE_DOUBLE: begin
				rateShift = 2'h1; // R01
				phaseMask = 2'h1;
			end
			RATE_QUAD: begin
				rateShift = 2'h2; // R15
				phaseMask = 2'h3;
			end
			default: begin
				rateShift = 2'h0;
				phaseMask = 2'h0;
			end
		endcase
		next_sampleRateHz = baseHz << rateShift; // R01 R15
		// fractional accumulators: index 0 runs the sample rate, index 1 the base rate
		for (int i = 0; i < 2; i++) begin
			sum[i] = acc[i] + `MSMM_ACC_W'((i == 0) ? next_sampleRateHz : baseHz);
			next_tick[i] = (sum[i] >= `MSMM_CLK_HZ);
			next_acc[i] = next_tick[i] ? sum[i] - `MSMM_CLK_HZ : sum[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc[0] <= 28'h0000000;
			acc[1] <= 28'h0000000;
			sampleTick <= 1'b0;
			baseTick <= 1'b0;
			sampleRateHz <= 18'h00000;
		end else if (clkEn) begin
			acc[0] <= next_acc[0];
			acc[1] <= next_acc[1];
			sampleTick <= next_tick[0];
			baseTick <= next_tick[1];
			sampleRateHz <= next_sampleRateHz;
		end
	end

	// ************************************************************
	// receive demultiplex
	// ************************************************************
	logic next_rxValid, next_rxNativeSeen, frameStart, next_frameStart;
	logic [`MSMM_SLOT_W-1:0] next_rxChan;
	logic [1:0] next_rxPhase;
	logic [`MSMM_SAMPLE_W-1:0] next_rxData;

	always_comb begin
		next_rxValid = 1'b0;
		next_rxChan = rxChan;
		next_rxPhase = rxPhase;
		next_rxData = rxData;
		next_rxNativeSeen = rxNativeSeen;
		next_frameStart = linkEdge && (sSlot == 6'h00);
		if (linkEdge) begin
			if (sSlot == 6'h00) next_rxNativeSeen = sNative; // R11
			if (rxNat) begin
				// native frame: slots above 31 carry no audio
				next_rxValid = !sSlot[5]; // R11 R03
				next_rxChan = sSlot;
				next_rxPhase = 2'h0;
			end else begin
				// rate cannot be seen in a standard frame: the set mode decides
				next_rxValid = 1'b1; // R12 R10
				next_rxChan = sSlot >> rateShift; // R04 R05
				// lower slot of a group holds the earlier sample
				next_rxPhase = sSlot[1:0] & phaseMask; // R08
			end
			next_rxData = sData; // R09 R02
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxValid <= 1'b0;
			rxChan <= 6'h00;
			rxPhase <= 2'h0;
			rxData <= 24'h000000;
			rxNativeSeen <= 1'b0;
			frameStart <= 1'b0;
		end else if (clkEn) begin
			rxValid <= next_rxValid;
			rxChan <= next_rxChan;
			rxPhase <= next_rxPhase;
			rxData <= next_rxData;
			rxNativeSeen <= next_rxNativeSeen;
			frameStart <= next_frameStart;
		end
	end

	// ************************************************************
	// transmit multiplex
	// ************************************************************
	logic txNat, next_txReq, next_linkTxValid, next_linkTxNative;
	logic [`MSMM_SLOT_W-1:0] txSlot, next_txSlot, reqSlot, next_reqSlot;
	logic [`MSMM_SLOT_W-1:0] next_txReqChan, next_linkTxSlot, lastSlot;
	logic [1:0] next_txReqPhase;
	logic [`MSMM_SAMPLE_W-1:0] next_linkTxData;

	// quad rate never selects the native frame
	assign txNat = (frameFormat == FMT_NATIVE) && (rateMode == RATE_DOUBLE); // R07 R03

	always_comb begin
		next_txReq = 1'b0;
		next_linkTxValid = 1'b0;
		next_txSlot = txSlot;
		next_reqSlot = reqSlot;
		next_txReqChan = txReqChan;
		next_txReqPhase = txReqPhase;
		next_linkTxSlot = linkTxSlot;
		next_linkTxData = linkTxData;
		next_linkTxNative = linkTxNative;
		lastSlot = txNat ? `MSMM_NAT_LAST_SLOT : `MSMM_STD_LAST_SLOT; // R10 R11
		if (linkEdge) begin
			next_txReq = 1'b1;
			next_reqSlot = txSlot;
			next_txReqChan = txNat ? txSlot : txSlot >> rateShift; // R04 R05
			next_txReqPhase = txNat ? 2'h0 : txSlot[1:0] & phaseMask; // R08
			// a mode change mid-frame may leave the slot past the new end
			next_txSlot = (txSlot >= lastSlot) ? 6'h00 : txSlot + 6'h01;
		end
		if (txReq) begin
			next_linkTxValid = 1'b1;
			next_linkTxSlot = reqSlot;
			next_linkTxData = txData; // R09 R02
			// multiplexed modes stay on the base-rate frame
			next_linkTxNative = txNat; // R06
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txReq <= 1'b0;
			txSlot <= 6'h00;
			reqSlot <= 6'h00;
			txReqChan <= 6'h00;
			txReqPhase <= 2'h0;
			linkTxValid <= 1'b0;
			linkTxSlot <= 6'h00;
			linkTxData <= 24'h000000;
			linkTxNative <= 1'b0;
		end else if (clkEn) begin
			txReq <= next_txReq;
			txSlot <= next_txSlot;
			reqSlot <= next_reqSlot;
			txReqChan <= next_txReqChan;
			txReqPhase <= next_txReqPhase;
			linkTxValid <= next_linkTxValid;
			linkTxSlot <= next_linkTxSlot;
			linkTxData <= next_linkTxData;
			linkTxNative <= next_linkTxNative;
		end
	end

	// ************************************************************
	// clock recovery status
	// ************************************************************
	msmm_lock_if lockBus ();
	assign lockBus.frameStart = frameStart;
	// a native frame runs at the doubled rate, so compare with the sample tick
	assign lockBus.refTick = rxNativeSeen ? sampleTick : baseTick;
	assign lockState = lockBus.lockState; // R14

	msmm_lock #(
		.MAX_PERIOD(LOCK_MAX_PERIOD)
	) u_lock (
		.clk(clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.bus(lockBus.meter)
	);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || !clkEn);

	// the first edge after reset still shows the reset value, so it is skipped
	AST_DOUBLE_RATE: assert property ( // R01
		($past(resetn) && $past(rateMode) == RATE_DOUBLE)
			|-> sampleRateHz == (($past(base48k) ? `MSMM_BASE48_HZ : `MSMM_BASE441_HZ) << 1))
		else $error("double rate clock not twice base");
	AST_QUAD_RATE: assert property ( // R15
		($past(resetn) && $past(rateMode) == RATE_QUAD)
			|-> sampleRateHz == (($past(base48k) ? `MSMM_BASE48_HZ : `MSMM_BASE441_HZ) << 2))
		else $error("quad rate clock not four times base");
	AST_RX_LOSSLESS: assert property ( // R09
		rxValid |-> rxData == $past(sData))
		else $error("received sample altered");
	AST_RX_DOUBLE_MAP: assert property ( // R04
		(rxValid && !$past(rxNat) && $past(rateMode) == RATE_DOUBLE)
			|-> (rxChan == ($past(sSlot) >> 1) && rxPhase == {1'b0, $past(sSlot[0])}))
		else $error("double rate slot mapping wrong");
	AST_RX_QUAD_MAP: assert property ( // R05
		(rxValid && !$past(rxNat) && $past(rateMode) == RATE_QUAD)
			|-> (rxChan == ($past(sSlot) >> 2) && rxPhase == $past(sSlot[1:0])))
		else $error("quad rate slot mapping wrong");
	AST_RX_SINGLE_MAP: assert property ( // R10
		(rxValid && !$past(rxNat) && $past(rateMode) == RATE_SINGLE) |-> rxChan == $past(sSlot))
		else $error("single rate slot mapping wrong");
	AST_RX_NATIVE: assert property ( // R11
		(linkEdge && rxNat && sSlot[5]) |=> !rxValid)
		else $error("native frame slot above 31 passed");
	AST_TX_ANSWER: assert property ( // R09
		txReq |=> (linkTxValid && linkTxData == $past(txData) && linkTxSlot == $past(reqSlot)))
		else $error("slot request not carried to link");
	AST_NO_QUAD_NATIVE: assert property ( // R07
		(linkTxValid && $past(rateMode) == RATE_QUAD) |-> !linkTxNative)
		else $error("quad rate sent in native frame");
	AST_TX_PHASE: assert property ( // R08
		(txReq && !$past(txNat) && $past(rateMode) == RATE_QUAD) |-> txReqPhase == reqSlot[1:0])
		else $error("transmit group order wrong");
	AST_STATE_CODE: assert property ( // R14
		lockState != 2'h3)
		else $error("illegal input state");
	CV_RX_QUAD: cover property (rxValid && rxPhase == 2'h3);
	CV_TX_NATIVE: cover property (linkTxValid && linkTxNative);
	CV_NATIVE_SEEN: cover property ($rose(rxNativeSeen));
endmodule : msmm_top
`default_nettype wire

// File: testbench/msmm_remote_model.sv
// Purpose: remote link device that sends frames of slot words
// Assumes: slot clock period of SLOT_NS, data stable around each rise
// Notes: slot clock stands still between frames
`include "msmm_map.svh"
`default_nettype none
module msmm_remote_model #(
	parameter int SLOT_NS = 160
) (
	output logic linkClk,
	output logic [`MSMM_SLOT_W-1:0] linkRxSlot,
	output logic [`MSMM_SAMPLE_W-1:0] linkRxData,
	output logic linkRxNative
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		linkClk = 1'b0;
		linkRxSlot = 6'h00;
		linkRxData = 24'h000000;
		linkRxNative = 1'b0;
	end
	// ************************************************************
	// one frame, always 64 slots so a native receiver must drop the top half
	// ************************************************************
	task automatic send_frame(input logic native);
		for (int s = 0; s < 64; s++) begin
			linkRxSlot = 6'(s);
			linkRxData = 24'($urandom);
			// marker toggles off slot 0 to show it is only read there
			linkRxNative = (s == 0) ? native : ~linkRxNative;
			#(SLOT_NS / 2);
			linkClk = 1'b1;
			#(SLOT_NS / 4);
			if (s == 63) begin
				// released lines must not keep the last word; done mid-slot so the
				// next frame's first word is not written in the same time step
				linkRxSlot = ~linkRxSlot;
				linkRxData = ~linkRxData;
				linkRxNative = ~linkRxNative;
			end
			#(SLOT_NS / 4);
			linkClk = 1'b0;
		end
	endtask : send_frame
endmodule : msmm_remote_model
`default_nettype wire

// File: testbench/msmm_top_tb.sv
// Purpose: self-checking bench of the sample multiplex mapper
// Assumes: router answers in the cycle of its request
// Notes: frames run back to back so the lock meter sees a steady period
`include "msmm_map.svh"
`default_nettype none
module msmm_top_tb
	import msmm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, resetn, clkEn, frameFormat, base48k, linkClk, linkRxNative;
	logic [1:0] rateMode, txReqPhase, rxPhase, lockState;
	logic [5:0] linkRxSlot, linkTxSlot, txReqChan, rxChan;
	logic [23:0] linkRxData, linkTxData, txData, rxData, sentTx;
	logic linkTxValid, linkTxNative, txReq, rxValid, rxNativeSeen, sampleTick, rxNat, txNat;
	logic [17:0] sampleRateHz;
	int fails, checkCount, wdCount, cycCount, tickCount, rxCount, shift, txShift, expTx;
	logic [1:0] modeRate [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
	logic modeFmt [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

	msmm_top #(.LOCK_MAX_PERIOD(3000)) i_msmm_top (.clk(clk), .resetn(resetn), .clkEn(clkEn),
		.rateMode(rateMode), .frameFormat(frameFormat), .base48k(base48k), .linkClk(linkClk),
		.linkRxSlot(linkRxSlot), .linkRxData(linkRxData), .linkRxNative(linkRxNative),
		.linkTxValid(linkTxValid), .linkTxSlot(linkTxSlot), .linkTxData(linkTxData),
		.linkTxNative(linkTxNative), .txReq(txReq), .txReqChan(txReqChan),
		.txReqPhase(txReqPhase), .txData(txData), .rxValid(rxValid), .rxChan(rxChan),
		.rxPhase(rxPhase), .rxData(rxData), .rxNativeSeen(rxNativeSeen),
		.sampleTick(sampleTick), .sampleRateHz(sampleRateHz), .lockState(lockState));
	msmm_remote_model i_msmm_remote_model (.linkClk(linkClk), .linkRxSlot(linkRxSlot),
		.linkRxData(linkRxData), .linkRxNative(linkRxNative));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ************************************************************
	// compare tasks and verdict
	// ************************************************************
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val
	task automatic check_range(input string what, input longint exp, input int got);
		checkCount++;
		// accumulator phase at release allows one tick either way
		if (got < exp - 1 || got > exp + 1) begin
			fails++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_range
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// ************************************************************
	// monitors, router and watchdog
	// ************************************************************
	always @(posedge clk) begin
		wdCount++;
		if (wdCount == 80000) begin
			fails++;
			tally_and_finish();
		end
		if (resetn === 1'b1) begin
			cycCount++;
			if (sampleTick === 1'b1) begin
				tickCount++;
			end
		end
		if (rxValid === 1'b1) begin
			rxCount++;
			check_val("rxChan", rxNat ? 32'(linkRxSlot) : 32'(linkRxSlot >> shift), 32'(rxChan));
			check_val("rxPhase", rxNat ? 0 : 32'(linkRxSlot & ((1 << shift) - 1)), 32'(rxPhase));
			check_val("rxData", 32'(linkRxData), 32'(rxData));
		end
		if (txReq === 1'b1) begin
			check_val("txReqChan", 32'(expTx >> txShift), 32'(txReqChan));
			check_val("txReqPhase", 32'(expTx & ((1 << txShift) - 1)), 32'(txReqPhase));
		end
		if (linkTxValid === 1'b1) begin
			check_val("linkTxSlot", 32'(expTx), 32'(linkTxSlot));
			check_val("linkTxData", 32'(sentTx), 32'(linkTxData));
			check_val("linkTxNative", 32'(txNat), 32'(linkTxNative));
			expTx = (expTx == (txNat ? 31 : 63)) ? 0 : expTx + 1;
		end
	end
	always @(posedge clk) begin
		#1;
		if (txReq === 1'b1) begin
			txData = 24'($urandom);
			sentTx = txData;
		end
	end
	// ************************************************************
	// one rate setting: reset, three frames, then rate, tick and lock checks
	// ************************************************************
	task automatic run_mode(input logic [1:0] rate, input logic fmt, input logic b48,
			input logic firstNat);
		int unsigned hz;
		@(posedge clk);
		#1;
		resetn = 1'b0;
		rateMode = rate;
		frameFormat = fmt;
		base48k = b48;
		shift = (rate == 2'h1) ? 1 : (rate == 2'h2) ? 2 : 0;
		txNat = (rate == 2'h1) && fmt;
		txShift = txNat ? 0 : shift;
		expTx = 0;
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
		cycCount = 0;
		tickCount = 0;
		for (int f = 0; f < 3; f++) begin
			rxNat = (f == 0) ? firstNat : 1'($urandom_range(0, 1));
			rxCount = 0;
			i_msmm_remote_model.send_frame(rxNat);
			check_val("rxCount", rxNat ? 32 : 64, 32'(rxCount));
			check_val("rxNativeSeen", 32'(rxNat), 32'(rxNativeSeen));
		end
		hz = (b48 ? 48000 : 44100) << shift;
		check_val("sampleRateHz", hz, 32'(sampleRateHz));
		check_range("sampleTick", longint'(cycCount) * hz / 250000000, tickCount);
		check_val("lockState", 32'(LOCK_VALID), 32'(lockState));
	endtask : run_mode

	initial begin
		void'($urandom(56829));
		resetn = 1'b0;
		clkEn = 1'b1;
		rateMode = 2'h0;
		frameFormat = 1'b0;
		base48k = 1'b0;
		txData = 24'h000000;
		for (int m = 0; m < 6; m++) begin
			run_mode(modeRate[m], modeFmt[m], 1'($urandom_range(0, 1)), 1'(m));
		end
		// clock enable low freezes the meter, so its timeout must not advance
		clkEn = 1'b0;
		repeat (3200) @(posedge clk);
		#1;
		check_val("lockState", 32'(LOCK_VALID), 32'(lockState));
		clkEn = 1'b1;
		// link goes silent: meter must drop lock after its window
		repeat (3200) @(posedge clk);
		check_val("lockState", 32'(LOCK_NONE), 32'(lockState));
		tally_and_finish();
	end
endmodule : msmm_top_tb
`default_nettype wire
